// *** hdl/hsq_map.vh ***
// constants for the hot-swap fault sequencer: timing, widths, states
// assumes a 10 MHz core clock and comparator inputs already digitised
`ifndef HSQ_MAP_VH
`define HSQ_MAP_VH

// core clock rate in MHz (period 100 ns)
`define HSQ_CLK_MHZ        10
// accumulated overcurrent time that trips the breaker, in us
`define HSQ_TRIP_TIME_US   500
// trip count in core cycles: 500 us at 10 MHz, sized to the integrator
`define HSQ_TRIP_CYCLES    13'h1388
// restart hold time after a fault, in us (plain default)
`define HSQ_HOLD_TIME_US   100000
// restart hold count in core cycles: hold time at 10 MHz, sized to the timer
`define HSQ_HOLD_CYCLES    20'hf4240
// integrator decrement is this many times slower than increment
`define HSQ_DECAY_RATIO    128
// last value of the decay prescaler
`define HSQ_DECAY_LAST     7'h7f

// counter widths
`define HSQ_INT_W          13
`define HSQ_HOLD_W         20
`define HSQ_DECAY_W        7

// synchronised input vector layout
`define HSQ_IN_W           9
`define HSQ_IN_UV          0
`define HSQ_IN_OV          1
`define HSQ_IN_LOCK        2
`define HSQ_IN_LIMIT       3
`define HSQ_IN_SENSE_LOW   4
`define HSQ_IN_OUT_LOW     5
`define HSQ_IN_NEAR_FULL   6
`define HSQ_IN_HOT         7
`define HSQ_IN_COOL        8

// sequencer state codes
`define HSQ_ST_IDLE        2'h0
`define HSQ_ST_RUN         2'h1
`define HSQ_ST_FAULT       2'h2

`endif

// *** hdl/hsq_sequencer.v ***
// hot-swap fault sequencer: decides pass-switch drive and power-good
// assumes digitised comparator levels, power-up drives resetn low
//
// Contract
// - undervoltage low switches the pass transistor off
// - current limit pulls drive down, releases after
// - integrate overcurrent, fault after 500us
// - decrement integrator 128 times slower
// - breaker trip latches fault, switches off
// - faults discharge drive with strong pulldown
// - overcurrent fault cleared by undervoltage toggle
// - restart waits hold time after fault
// - undervoltage low or overvoltage high disables
// - supply lockout keeps transistor off
// - start only with all conditions good
// - active-low variant pulls power-good when good
// - active-low variant releases power-good otherwise
// - active-high variant clamps until power good; pin released during reset and the first cycle after
// - thermal trip pulls drive low
// - thermal clear by toggle, then hold time
// - thermal restart only after cooling 20C
// - early reset request, restart deferred
// - power-good latched once output low, drive full
`timescale 1ns/1ps
`include "hsq_map.vh"

module hsq_sequencer #(
  parameter [`HSQ_INT_W-1:0]  TRIP_CYCLES = `HSQ_TRIP_CYCLES, // breaker trip count
  parameter [`HSQ_HOLD_W-1:0] HOLD_CYCLES = `HSQ_HOLD_CYCLES  // restart hold count
) (
  input  wire core_clk,                 // core clock, 10 MHz
  input  wire resetn,                   // synchronous reset, active low
  input  wire pg_active_high,           // variant strap, caught after reset
  input  wire undervoltage_input,       // high when above release level
  input  wire supply_high_trip_input,   // high while overvoltage
  input  wire supply_lockout_ok,        // high when above release level
  input  wire current_limit_hit,        // shunt at current limit threshold
  input  wire sense_below_start,        // shunt below start level
  input  wire output_low,               // output node below low threshold
  input  wire drive_near_full,          // drive close to full level
  input  wire thermal_trip,             // die at thermal trip threshold
  input  wire thermal_cool,             // die cooled below restart level
  input  wire power_good_output_in,     // sensed level of power-good pin
  output reg  power_good_output_out,    // power-good pin drive value
  output reg  power_good_output_oe,     // power-good pin pulldown enable
  output reg  drive_charge,             // charge current source on
  output reg  drive_regulate,           // regulation pulldown on
  output reg  drive_discharge,          // strong discharge on
  output reg  overcurrent_fault,        // latched breaker fault
  output reg  thermal_fault,            // latched thermal fault
  output reg  power_good                // latched power-good status
);

  // synchronised inputs
  wire [`HSQ_IN_W-1:0] raw_in;           // raw comparator levels
  wire [`HSQ_IN_W-1:0] sync_in;          // synchronised levels
  wire                 s_uv;             // undervoltage input, synced
  wire                 s_ov;             // overvoltage input, synced
  wire                 s_lock;           // lockout released, synced
  wire                 s_limit;          // at current limit, synced
  wire                 s_sense_low;      // shunt below start, synced
  wire                 s_out_low;        // output node low, synced
  wire                 s_near_full;      // drive near full, synced
  wire                 s_hot;            // thermal trip, synced
  wire                 s_cool;           // cooled enough, synced

  // sequencer state
  reg  [1:0]              state;         // current state
  reg  [1:0]              next_state;    // next state
  reg  [`HSQ_INT_W-1:0]   int_cnt;       // overcurrent integrator
  reg  [`HSQ_DECAY_W-1:0] decay_cnt;     // decay prescaler
  reg  [`HSQ_HOLD_W-1:0]  hold_cnt;      // restart hold timer
  reg                     hold_done;     // hold time has elapsed
  reg                     oc_latched;    // breaker fault latch
  reg                     th_latched;    // thermal fault latch
  reg                     wait_cool;     // waiting for die to cool
  reg                     uv_prev;       // last undervoltage level
  reg                     uv_low_seen;   // reset request accepted
  reg                     pg_latched;    // power-good latch
  reg                     variant_high;  // captured variant strap
  reg                     strap_taken;   // strap already captured

  // combinational helpers
  wire supply_ok;                        // uv high, ov low, lockout ok
  wire start_ok;                         // all start conditions hold
  wire oc_trip;                          // breaker trips this cycle
  wire th_event;                         // thermal trip this cycle
  wire uv_rise;                          // undervoltage rising edge
  wire clear_req;                        // toggle completes a reset
  wire next_pg;                          // next power-good latch

  assign raw_in[`HSQ_IN_UV]        = undervoltage_input;
  assign raw_in[`HSQ_IN_OV]        = supply_high_trip_input;
  assign raw_in[`HSQ_IN_LOCK]      = supply_lockout_ok;
  assign raw_in[`HSQ_IN_LIMIT]     = current_limit_hit;
  assign raw_in[`HSQ_IN_SENSE_LOW] = sense_below_start;
  assign raw_in[`HSQ_IN_OUT_LOW]   = output_low;
  assign raw_in[`HSQ_IN_NEAR_FULL] = drive_near_full;
  assign raw_in[`HSQ_IN_HOT]       = thermal_trip;
  assign raw_in[`HSQ_IN_COOL]      = thermal_cool;

  hsq_sync #(
    .W        (`HSQ_IN_W)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign s_uv        = sync_in[`HSQ_IN_UV];
  assign s_ov        = sync_in[`HSQ_IN_OV];
  assign s_lock      = sync_in[`HSQ_IN_LOCK];
  assign s_limit     = sync_in[`HSQ_IN_LIMIT];
  assign s_sense_low = sync_in[`HSQ_IN_SENSE_LOW];
  assign s_out_low   = sync_in[`HSQ_IN_OUT_LOW];
  assign s_near_full = sync_in[`HSQ_IN_NEAR_FULL];
  assign s_hot       = sync_in[`HSQ_IN_HOT];
  assign s_cool      = sync_in[`HSQ_IN_COOL];

  assign supply_ok = s_uv & ~s_ov & s_lock;

  assign start_ok = supply_ok & s_sense_low & ~oc_latched & ~th_latched
                  & hold_done & ~wait_cool & ~s_hot;

  // breaker trips on the last integrator step
  assign oc_trip = (state == `HSQ_ST_RUN) & s_limit
                 & (int_cnt == TRIP_CYCLES - 1'b1);

  // thermal trip acts in any state
  assign th_event = s_hot;

  // reset request edge on the undervoltage input
  assign uv_rise   = s_uv & ~uv_prev;
  assign clear_req = uv_rise & uv_low_seen;

  // sequencer next state
  always @*
  begin
    next_state = state;
    case (state)
      `HSQ_ST_IDLE:
      begin
        // lockout and window block the start
        if (th_event)
          next_state = `HSQ_ST_FAULT;
        else if (start_ok)
          next_state = `HSQ_ST_RUN;
      end
      `HSQ_ST_RUN:
      begin
        // breaker or thermal trip latches off
        if (oc_trip || th_event)
          next_state = `HSQ_ST_FAULT;
        else if (!supply_ok)
          next_state = `HSQ_ST_IDLE;
      end
      `HSQ_ST_FAULT:
      begin
        // restart waits in idle for the hold
        if (!oc_latched && !th_latched && !th_event)
          next_state = `HSQ_ST_IDLE;
      end
      default:
        next_state = `HSQ_ST_IDLE;
    endcase
  end

  assign next_pg = (next_state == `HSQ_ST_RUN)
                 & (pg_latched | (s_out_low & s_near_full));

  // state register and input history
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state   <= `HSQ_ST_IDLE;
      uv_prev <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      uv_prev <= s_uv;
    end
  end

  // variant strap, caught on the first edge after release
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      strap_taken  <= 1'b0;
      variant_high <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken  <= 1'b1;
      variant_high <= pg_active_high;
    end
  end

  // overcurrent integrator with slow decay
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      int_cnt   <= {`HSQ_INT_W{1'b0}};
      decay_cnt <= {`HSQ_DECAY_W{1'b0}};
    end
    else if (oc_trip)
    begin
      // start from empty after a trip
      int_cnt   <= {`HSQ_INT_W{1'b0}};
      decay_cnt <= {`HSQ_DECAY_W{1'b0}};
    end
    else if (state == `HSQ_ST_RUN && s_limit)
    begin
      int_cnt   <= int_cnt + 1'b1;
      decay_cnt <= {`HSQ_DECAY_W{1'b0}};
    end
    else if (int_cnt != {`HSQ_INT_W{1'b0}})
    begin
      // one step down per 128 ticks
      if (decay_cnt == `HSQ_DECAY_LAST)
        int_cnt <= int_cnt - 1'b1;
      decay_cnt <= decay_cnt + 1'b1;
    end
    else
      decay_cnt <= {`HSQ_DECAY_W{1'b0}};
  end

  // fault latches; a new fault wins over a clear
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      oc_latched  <= 1'b0;
      th_latched  <= 1'b0;
      wait_cool   <= 1'b0;
      uv_low_seen <= 1'b0;
    end
    else
    begin
      if (oc_trip)
        oc_latched <= 1'b1;
      // cleared by a low then high undervoltage
      else if (clear_req)
        oc_latched <= 1'b0;
      if (th_event)
        th_latched <= 1'b1;
      else if (clear_req)
        th_latched <= 1'b0;
      if (th_event)
        wait_cool <= 1'b1;
      else if (s_cool)
        wait_cool <= 1'b0;
      // low level taken as request at once
      if ((oc_latched || th_latched) && !s_uv)
        uv_low_seen <= 1'b1;
      else if (uv_rise)
        uv_low_seen <= 1'b0;
    end
  end

  // restart hold timer
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      hold_cnt  <= {`HSQ_HOLD_W{1'b0}};
      hold_done <= 1'b1;
    end
    else if (oc_trip || (th_event && !th_latched))
    begin
      hold_cnt  <= {`HSQ_HOLD_W{1'b0}};
      hold_done <= 1'b0;
    end
    else if (clear_req && th_latched)
    begin
      hold_cnt  <= {`HSQ_HOLD_W{1'b0}};
      hold_done <= 1'b0;
    end
    else if (!hold_done)
    begin
      if (hold_cnt == HOLD_CYCLES - 1'b1)
        hold_done <= 1'b1;
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // registered drive and status outputs
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      drive_charge          <= 1'b0;
      drive_regulate        <= 1'b0;
      drive_discharge       <= 1'b1;
      pg_latched            <= 1'b0;
      power_good            <= 1'b0;
      overcurrent_fault     <= 1'b0;
      thermal_fault         <= 1'b0;
      power_good_output_out <= 1'b0;
      power_good_output_oe  <= 1'b0;
    end
    else
    begin
      // regulate while at limit, charge otherwise
      drive_charge    <= (next_state == `HSQ_ST_RUN) & ~s_limit;
      drive_regulate  <= (next_state == `HSQ_ST_RUN) & s_limit;
      drive_discharge <= (next_state != `HSQ_ST_RUN);
      pg_latched      <= next_pg;
      power_good      <= next_pg;
      overcurrent_fault <= oc_latched | oc_trip;
      thermal_fault     <= th_latched | th_event;
      // open-drain pin only ever pulls low
      power_good_output_out <= 1'b0;
      // active-high variant clamps when not good
      if (variant_high)
        power_good_output_oe <= ~next_pg;
      else
        power_good_output_oe <= next_pg;
    end
  end

endmodule // hsq_sequencer

// *** hdl/hsq_sync.v ***
// two-flop synchroniser for a vector of comparator and monitor levels
// assumes each bit is an independent level; no bus coherence implied
`timescale 1ns/1ps

module hsq_sync #(
  parameter W = 9                          // number of bits
) (
  input  wire         core_clk,            // core clock
  input  wire         resetn,              // synchronous reset, active low
  input  wire [W-1:0] async_in,            // raw levels
  output wire [W-1:0] sync_out             // synchronised levels
);

  genvar gi;

  // one two-stage chain per bit; stage one feeds only stage two
  generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_bit
      reg stage1;                           // metastability catcher
      reg stage2;                           // settled copy
      always @(posedge core_clk)
      begin
        if (!resetn)
        begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end
        else
        begin
          stage1 <= async_in[gi];
          stage2 <= stage1;
        end
      end
      assign sync_out[gi] = stage2;
    end
  endgenerate

endmodule // hsq_sync

// *** tb/hot_swap_fault_sequencer_test.sv ***
// self-checking bench for the hot-swap fault sequencer
// assumes the pass model on the drive side and short count parameters
`timescale 1ns/1ps

module hot_swap_fault_sequencer_test;
  localparam logic [12:0] TRIP = 13'h14;       // breaker count, 20
  localparam logic [19:0] HOLD = 20'h32;       // restart hold, 50
  logic core_clk = 1'b0;                       // 10 MHz clock
  logic resetn = 1'b0;                         // reset, active low
  logic pg_active_high = 1'b0;                 // variant strap
  logic undervoltage_input = 1'b0;             // undervoltage level
  logic supply_high_trip_input = 1'b0;         // overvoltage level
  logic supply_lockout_ok = 1'b0;              // supply lockout
  logic thermal_trip = 1'b0;                   // die too hot
  logic thermal_cool = 1'b1;                   // die cooled
  logic short_load = 1'b0;                     // overload request
  wire  current_limit_hit, sense_below_start, output_low, drive_near_full;
  wire  power_good_output_in, power_good_output_out, power_good_output_oe;
  wire  drive_charge, drive_regulate, drive_discharge;
  wire  overcurrent_fault, thermal_fault, power_good;
  // rows: undervoltage, overvoltage, lockout ok, expected charge
  logic [3:0] rows [5] = '{4'hb, 4'h2, 4'he, 4'h8, 4'hb};
  int mismatches = 0;                          // failed comparisons
  int samples_checked = 0;                     // comparisons made
  int cycles = 0;                              // timeout counter
  int n;                                       // wait counter
  int i;                                       // row index

  hsq_sequencer #(.TRIP_CYCLES(TRIP), .HOLD_CYCLES(HOLD)) i_dut (
    .core_clk, .resetn, .pg_active_high, .undervoltage_input, .supply_high_trip_input,
    .supply_lockout_ok, .current_limit_hit, .sense_below_start, .output_low,
    .drive_near_full, .thermal_trip, .thermal_cool, .power_good_output_in,
    .power_good_output_out, .power_good_output_oe, .drive_charge, .drive_regulate,
    .drive_discharge, .overcurrent_fault, .thermal_fault, .power_good);
  hsq_pass_model i_pass (
    .core_clk, .drive_charge, .drive_regulate, .drive_discharge, .short_load,
    .power_good_output_oe, .drive_near_full, .output_low, .current_limit_hit,
    .sense_below_start, .power_good_output_in);

  always #50 core_clk = ~core_clk;

  // settle after k rising edges
  task automatic look(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // compare one output bit
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %0t output mismatch", $time);
    end
  endtask

  // verdict and end of run
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // reset for three cycles with a chosen variant
  task automatic do_reset(input logic variant);
    @(posedge core_clk);
    resetn         <= 1'b0;
    pg_active_high <= variant;
    look(2);
    chk(drive_discharge, 1'b1);
    chk(overcurrent_fault, 1'b0);
    @(posedge core_clk);
    resetn <= 1'b1;
  endtask

  // cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      final_report;
    end
  end

  initial
  begin
    do_reset(1'b0);
    for (i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      undervoltage_input     <= rows[i][3];
      supply_high_trip_input <= rows[i][2];
      supply_lockout_ok      <= rows[i][1];
      look(8);
      chk(drive_charge, rows[i][0]);
      chk(drive_discharge, !rows[i][0]);
    end
    look(15);
    chk(power_good, 1'b1);
    chk(power_good_output_oe, 1'b1);
    chk(power_good_output_out, 1'b0);
    // hard short until the breaker trips
    @(posedge core_clk);
    short_load <= 1'b1;
    look(6);
    chk(drive_regulate, 1'b1);
    n = 6;
    while (overcurrent_fault !== 1'b1 && n < 60)
    begin
      look(1);
      n++;
    end
    chk(n >= TRIP && n <= TRIP + 8, 1'b1);
    chk(drive_discharge, 1'b1);
    chk(power_good, 1'b0);
    @(posedge core_clk);
    undervoltage_input <= 1'b0;
    short_load         <= 1'b0;
    repeat (3) @(posedge core_clk);
    undervoltage_input <= 1'b1;
    look(HOLD - 15);
    chk(overcurrent_fault, 1'b0);
    chk(drive_charge, 1'b0);
    look(20);
    chk(drive_charge, 1'b1);
    // two overload bursts, decay between them is slow
    look(20);
    @(posedge core_clk);
    short_load <= 1'b1;
    repeat (10) @(posedge core_clk);
    short_load <= 1'b0;
    look(100);
    chk(overcurrent_fault, 1'b0);
    chk(drive_charge, 1'b1);
    @(posedge core_clk);
    short_load <= 1'b1;
    repeat (15) @(posedge core_clk);
    short_load <= 1'b0;
    look(5);
    chk(overcurrent_fault, 1'b1);
    // reset while latched, other variant, no hold wait
    do_reset(1'b1);
    look(8);
    chk(drive_charge, 1'b1);
    chk(power_good_output_oe, 1'b1);
    look(15);
    chk(power_good_output_oe, 1'b0);
    // thermal trip, toggle, then cool down
    @(posedge core_clk);
    thermal_trip <= 1'b1;
    thermal_cool <= 1'b0;
    look(5);
    chk(thermal_fault, 1'b1);
    chk(drive_discharge, 1'b1);
    @(posedge core_clk);
    thermal_trip       <= 1'b0;
    undervoltage_input <= 1'b0;
    repeat (3) @(posedge core_clk);
    undervoltage_input <= 1'b1;
    look(10);
    chk(drive_charge, 1'b0);
    @(posedge core_clk);
    thermal_cool <= 1'b1;
    look(20);
    chk(drive_charge, 1'b0);
    look(40);
    chk(drive_charge, 1'b1);
    final_report;
  end
endmodule // hot_swap_fault_sequencer_test

bind hsq_sequencer hsq_sequencer_chk #(
  .TRIP_CYCLES(TRIP_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES)
) i_chk (
  .core_clk, .resetn, .pg_active_high, .undervoltage_input, .supply_high_trip_input,
  .supply_lockout_ok, .current_limit_hit, .sense_below_start, .output_low,
  .drive_near_full, .thermal_trip, .power_good_output_oe, .drive_charge, .drive_regulate,
  .drive_discharge, .overcurrent_fault, .thermal_fault, .power_good);

// *** tb/hsq_pass_model.sv ***
// far side: pass transistor gate, load and power module with pull-up
// assumes the sequencer drive outputs and a bench overload request
`timescale 1ns/1ps

module hsq_pass_model (
  input  wire logic core_clk,                  // core clock
  input  wire logic drive_charge,              // charge source on
  input  wire logic drive_regulate,            // regulation pulldown on
  input  wire logic drive_discharge,           // strong pulldown on
  input  wire logic short_load,                // bench asks for overload
  input  wire logic power_good_output_oe,      // pin pulldown on
  output wire logic drive_near_full,           // gate near full level
  output wire logic output_low,                // output node pulled down
  output wire logic current_limit_hit,         // shunt at limit
  output wire logic sense_below_start,         // shunt below start
  output wire logic power_good_output_in       // pin level
);
  logic [3:0] gate = 4'h0;                     // gate level in steps

  // gate charges slowly, regulation holds it just on, pulldown empties it
  always @(posedge core_clk)
  begin
    if (drive_discharge)
      gate <= 4'h0;
    else if (drive_regulate && gate > 4'h1)
      gate <= gate - 4'h1;
    else if (drive_charge && gate < 4'h8)
      gate <= gate + 4'h1;
  end

  assign current_limit_hit    = short_load && gate != 4'h0;
  assign sense_below_start    = !current_limit_hit;
  assign drive_near_full      = gate == 4'h8;
  assign output_low           = drive_near_full && !short_load;
  // module pull-up lifts the released pin
  assign power_good_output_in = power_good_output_oe ? 1'b0 : 1'b1;
endmodule // hsq_pass_model

// *** tb/hsq_sequencer_chk.sv ***
// checker for the hot-swap fault sequencer, watching its ports only
// assumes one clock, synchronous active-low reset, 2 to 4 cycle input latency
`timescale 1ns/1ps

module hsq_sequencer_chk #(
  parameter int TRIP_CYCLES = 20,              // breaker trip count
  parameter int HOLD_CYCLES = 50               // restart hold count
) (
  input wire logic core_clk,                   // core clock
  input wire logic resetn,                     // reset, active low
  input wire logic pg_active_high,             // variant strap
  input wire logic undervoltage_input,         // undervoltage level
  input wire logic supply_high_trip_input,     // overvoltage level
  input wire logic supply_lockout_ok,          // supply above lockout
  input wire logic current_limit_hit,          // shunt at limit
  input wire logic sense_below_start,          // shunt below start
  input wire logic output_low,                 // output node low
  input wire logic drive_near_full,            // drive near full
  input wire logic thermal_trip,               // die too hot
  input wire logic power_good_output_oe,       // pin pulldown on
  input wire logic drive_charge,               // charge source on
  input wire logic drive_regulate,             // regulation on
  input wire logic drive_discharge,            // strong pulldown on
  input wire logic overcurrent_fault,          // breaker latch
  input wire logic thermal_fault,              // thermal latch
  input wire logic power_good                  // power-good latch
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);

  int   since;                                 // cycles since a fault rose
  int   reg_run;                               // unbroken regulate cycles
  logic oc_q;                                  // breaker latch one cycle back
  logic th_q;                                  // thermal latch one cycle back

  // hold timer restarts on each new fault, saturates at the hold count
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      since   <= HOLD_CYCLES;
      reg_run <= 0;
      oc_q    <= 1'b0;
      th_q    <= 1'b0;
    end
    else
    begin
      oc_q    <= overcurrent_fault;
      th_q    <= thermal_fault;
      reg_run <= drive_regulate ? reg_run + 1 : 0;
      if ((overcurrent_fault && !oc_q) || (thermal_fault && !th_q))
        since <= 0;
      else if (since < HOLD_CYCLES)
        since <= since + 1;
    end
  end

  // undervoltage released for 8 samples with no reset between
  sequence s_uv_high8;
    (undervoltage_input && resetn) [*8];
  endsequence
  // start conditions as seen two samples back
  sequence s_start_cause;
    $past(undervoltage_input, 2) && !$past(supply_high_trip_input, 2) &&
      $past(supply_lockout_ok, 2) && $past(sense_below_start, 2) && !$past(thermal_trip, 2);
  endsequence
  // output low and drive full two samples back
  sequence s_pg_cause;
    $past(output_low, 2) && $past(drive_near_full, 2);
  endsequence

  AST_UV_OFF: assert property ($fell(undervoltage_input) |-> ##[1:5] drive_discharge)
    else $error("drive left on after undervoltage");
  AST_OV_OFF: assert property ($rose(supply_high_trip_input) |-> ##[1:5] drive_discharge)
    else $error("drive left on after overvoltage");
  AST_LOCK_OFF: assert property (!supply_lockout_ok [*6] |-> drive_discharge)
    else $error("drive on below supply lockout");
  AST_START_GOOD: assert property ($rose(drive_charge) |-> s_start_cause)
    else $error("drive started without all start conditions");
  AST_REG_LIMIT: assert property ($rose(current_limit_hit) && drive_charge |->
    ##[1:5] (drive_regulate || drive_discharge))
    else $error("no regulation at current limit");
  AST_TRIP_BOUND: assert property (reg_run <= TRIP_CYCLES + 2)
    else $error("regulation outlasted trip count");
  AST_TRIP_OFF: assert property ($rose(overcurrent_fault) |->
    drive_discharge && !drive_charge && !power_good)
    else $error("breaker trip left drive on");
  AST_OC_HOLD: assert property (s_uv_high8 ##0 $past(overcurrent_fault, 1) |->
    overcurrent_fault)
    else $error("breaker latch cleared without toggle");
  AST_HOLD_WAIT: assert property ($rose(drive_charge) |-> since >= HOLD_CYCLES - 2)
    else $error("restart before hold time");
  AST_PG_POL: assert property (power_good |-> power_good_output_oe != pg_active_high)
    else $error("power-good pin polarity wrong");
  AST_PG_LATCH: assert property ($rose(power_good) |-> s_pg_cause ##0 !drive_discharge)
    else $error("power good without its cause");
  AST_THERMAL: assert property ($rose(thermal_trip) |->
    ##[1:5] (thermal_fault && drive_discharge))
    else $error("no thermal shutdown");
endmodule // hsq_sequencer_chk
